// ---- bench/acx_calc_assertions.sv ----
module acx_calc_assertions
(
  // Watched ports
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic tk;
  assign tk = tx_valid && tx_ready;
  // ====
  // Reply framing
  AST_BUSY: assert property (tx_valid |-> !rx_ready) else $error("rx open");
  AST_GAP: assert property ($fell(rx_ready) |=> tx_valid) else $error("late");
  AST_HOST: assert property ($rose(tx_valid) |-> tx_data == 8'h02) else $error("host");
  AST_TGT: assert property (tk && tx_data == 8'h02 |=> tx_data == 8'h01) else $error("tgt");
  AST_ECHO: assert property (tk && tx_data == 8'h64 |=> tx_data inside {8'h2A, 8'h2B}) else $error("echo");
  AST_ZERO: assert property (tk && tx_data inside {8'h2A, 8'h2B} |=> (tx_data == 8'h00) [*4]) else $error("val");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("hold");
  AST_END: assert property (tk && tx_data inside {8'h91, 8'h92} |=> !tx_valid && rx_ready) else $error("end");
  AST_REOPEN: assert property ($rose(rx_ready) |-> $past(tk)) else $error("reopen");
endmodule

bind acx_calc acx_calc_assertions acx_calc_assertions_inst (.clk, .reset, .rx_ready, .tx_valid, .tx_data, .tx_ready);

// ---- bench/acx_host.sv ----
module acx_host
(
  // Block side
  input  wire logic       clk,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rep [9];
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // ====
  // Frame out, reply in
  task automatic xfer(input logic [0:7][7:0] f, input logic slow, bad);
    logic [7:0] s;
    int j;
    s = {7'h00, bad};
    j = 0;
    rep = '{default: 8'hEE};
    // sum checksum, byte held until taken
    for (int i = 0; i < 9; i++)
    begin
      rx_valid <= 1'b1;
      rx_data <= (i < 8) ? f[i] : s;
      s = s + ((i < 8) ? f[i] : 8'h00);
      @(posedge clk);
      while (!rx_ready)
        @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~s;
    for (int k = 0; k < 60 && j < 9 && !bad; k++)
    begin
      tx_ready <= !slow || !tx_ready;
      @(posedge clk);
      if (tx_valid && tx_ready)
      begin
        rep[j] = tx_data;
        j++;
      end
    end
    tx_ready <= 1'b0;
  endtask
endmodule

// ---- bench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] VA = 32'hFFFFFF9C;
  localparam logic [31:0] VB = 32'h00000007;
  logic        clk, reset, rx_valid, rx_ready, tx_valid, tx_ready, xreg_wr, accu_wr, var_wr;
  logic [7:0]  rx_data, tx_data, var_idx;
  logic [31:0] xreg_wdata, accu_wdata, var_wdata, var_rdata, accu, xreg;
  int          n_fail, compares;
  acx_calc acx_calc_inst (.clk, .reset, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .xreg_wr,
    .xreg_wdata, .accu_wr, .accu_wdata, .var_wr, .var_idx, .var_wdata, .var_rdata, .accu, .xreg);
  acx_host acx_host_inst (.clk, .rx_ready, .tx_valid, .tx_data, .rx_valid, .rx_data, .tx_ready);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ====
  // Helpers
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] op(input int t, input logic [31:0] d, s);
    case (t)
      0: return d + s;
      1: return d - s;
      2: return d * s;
      3: return $signed(d) / $signed(s);
      4: return $signed(d) % $signed(s);
      5: return d & s;
      6: return d | s;
      7: return d ^ s;
      8: return ~s;
      9, 10: return s;
      default: return d;
    endcase
  endfunction
  task automatic load(input logic [31:0] v);
    {accu_wr, xreg_wr, var_wr} <= 3'b111;
    {accu_wdata, xreg_wdata, var_wdata} <= {VA, VB, v};
    @(posedge clk);
    {accu_wr, xreg_wr, var_wr} <= 3'b000;
    @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] ins, t, input logic slow, bad);
    logic [7:0] e [9];
    e = '{8'h02, 8'h01, 8'h64, ins, 8'h00, 8'h00, 8'h00, 8'h00, 8'h67 + ins};
    acx_host_inst.xfer({8'h01, ins, t, 8'hFF, 8'hA5, 8'hA5, 8'hA5, 8'hA5}, slow, bad);
    repeat (4) @(posedge clk);
    for (int j = 0; j < 9 && !bad; j++)
      chk("reply", acx_host_inst.rep[j], e[j]);
  endtask
  // ====
  // Scenarios
  task automatic t_calc(input logic [7:0] ins);
    for (int t = 0; t < 12; t++)
    begin
      load(ins[0] ? VA : VB);
      frame(ins, t[7:0], t[0], 1'b0);
      chk("dst", ins[0] ? var_rdata : accu, op(t, VA, VB));
      chk("src", ins[0] ? xreg : var_rdata, t == 10 ? VA : VB);
    end
  endtask
  task automatic t_bad;
    load(VB);
    frame(8'h2A, 8'h00, 1'b0, 1'b1);
    chk("txv", tx_valid, 32'h0);
    chk("accu", accu, VA);
    acx_host_inst.xfer({8'h03, 8'h2A, 8'h00, 8'hFF, 32'h00000000}, 1'b0, 1'b0);
    chk("tgt", acx_host_inst.rep[0], 32'h000000EE);
    acx_host_inst.xfer({8'h01, 8'h2C, 8'h00, 8'hFF, 32'h00000000}, 1'b0, 1'b0);
    chk("ins", acx_host_inst.rep[0], 32'h000000EE);
    acx_host_inst.xfer({8'h01, 8'h2A, 8'h0C, 8'hFF, 32'h00000000}, 1'b0, 1'b0);
    chk("typ", acx_host_inst.rep[0], 32'h000000EE);
    chk("txv", tx_valid, 32'h0);
    chk("accu", accu, VA);
    frame(8'h2A, 8'h00, 1'b0, 1'b0);
    chk("accu", accu, VA + VB);
  endtask
  task automatic t_reset;
    load(VB);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("accu0", accu, 32'h0);
    chk("xreg0", xreg, 32'h0);
    chk("rxr", rx_ready, 32'h1);
    chk("txv0", tx_valid, 32'h0);
    chk("txd0", tx_data, 32'h0);
    frame(8'h2A, 8'h00, 1'b1, 1'b0);
    chk("accu", accu, VB);
  endtask
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
  initial
  begin
    reset = 1'b1;
    {xreg_wr, accu_wr, var_wr} = 3'b000;
    {xreg_wdata, accu_wdata, var_wdata} = '0;
    var_idx = 8'hFF;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_calc(8'h2A);
    t_calc(8'h2B);
    t_bad;
    t_reset;
    end_of_test;
  end
endmodule

// ---- common/acx_pkg.sv ----
package acx_pkg;

  // =============================================
  // Operation codes
  typedef enum logic [3:0] {
    ACX_OP_ADD, ACX_OP_SUB, ACX_OP_MUL, ACX_OP_DIV, ACX_OP_MOD, ACX_OP_AND,
    ACX_OP_OR, ACX_OP_XOR, ACX_OP_NOT, ACX_OP_LOAD, ACX_OP_SWAP, ACX_OP_COMP
  } acx_op_t;

  // =============================================
  // Controller states
  typedef enum logic [1:0] {
    ACX_ST_RX, ACX_ST_EXEC, ACX_ST_TX
  } acx_fsm_t;

  typedef struct packed {
    acx_fsm_t        state;
    logic [3:0]      cnt;
    logic [8:0][7:0] frm;
    logic [7:0]      sum;
    logic [7:0]      txb;
    logic [31:0]     accu;
    logic [31:0]     xreg;
  } acx_state_t;

endpackage

// ---- common/acx_regs.svh ----
`ifndef ACX_REGS_SVH
`define ACX_REGS_SVH

// =============================================
// Frame constants
`define ACX_INSTR_ACCU   8'h2A
`define ACX_INSTR_UVAR   8'h2B
`define ACX_STATUS_OK    8'h64
`define ACX_TARGET_ADDR  8'h01
`define ACX_HOST_ADDR    8'h02
`define ACX_TYPE_MAX     8'h0B
`define ACX_LAST_BYTE    4'h8
`define ACX_NUM_VARS     256

// =============================================
// Reset values
`define ACX_ACCU_RESET   32'h00000000
`define ACX_XREG_RESET   32'h00000000
`endif

// ---- verilog/acx_calc.sv ----
`include "acx_regs.svh"

module acx_calc
  import acx_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Command bytes from host
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  // Reply bytes to host
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  // Local register access
  input  wire logic        xreg_wr,
  input  wire logic [31:0] xreg_wdata,
  input  wire logic        accu_wr,
  input  wire logic [31:0] accu_wdata,
  input  wire logic        var_wr,
  input  wire logic [7:0]  var_idx,
  input  wire logic [31:0] var_wdata,
  output logic [31:0]      var_rdata,
  output logic [31:0]      accu,
  output logic [31:0]      xreg
);

  // =============================================
  // State and variable store
  acx_state_t  s_reg;
  acx_state_t  s_next;
  logic [31:0] vars [`ACX_NUM_VARS];
  logic [31:0] var_rd;
  logic        var_we;
  logic [7:0]  var_wi;
  logic [31:0] var_wd;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] res;
  logic        to_accu;
  logic [3:0]  op_code;
  logic [7:0]  rsum;
  logic        frame_ok;

  assign var_rd    = vars[s_reg.frm[3]];
  assign rx_ready  = (s_reg.state == ACX_ST_RX);
  assign tx_valid  = (s_reg.state == ACX_ST_TX);
  assign tx_data   = s_reg.txb;
  assign accu      = s_reg.accu;
  assign xreg      = s_reg.xreg;
  assign to_accu   = (s_reg.frm[1] == `ACX_INSTR_ACCU);
  assign op_code   = s_reg.frm[2][3:0];

  // =============================================
  // Operand selection: a is the destination, b the source
  always_comb
  begin
    if (to_accu)
    begin
      op_a = s_reg.accu;
      op_b = var_rd;
    end
    else
    begin
      op_a = var_rd;
      op_b = s_reg.xreg;
    end
  end

  // =============================================
  // Arithmetic and logic unit
  always_comb
  begin
    res = op_a;
    case (acx_op_t'(op_code))
      ACX_OP_ADD:  res = op_a + op_b;
      ACX_OP_SUB:  res = op_a - op_b;
      ACX_OP_MUL:  res = 32'($signed(op_a) * $signed(op_b));
      ACX_OP_DIV:  res = (op_b == 32'h0) ? op_a : 32'($signed(op_a) / $signed(op_b));
      ACX_OP_MOD:  res = (op_b == 32'h0) ? op_a : 32'($signed(op_a) % $signed(op_b));
      ACX_OP_AND:  res = op_a & op_b;
      ACX_OP_OR:   res = op_a | op_b;
      ACX_OP_XOR:  res = op_a ^ op_b;
      ACX_OP_NOT:  res = ~op_b;
      ACX_OP_LOAD: res = op_b;
      default:     res = op_a;
    endcase
  end

  // Reply checksum over the eight leading bytes
  assign rsum = 8'(`ACX_HOST_ADDR + `ACX_TARGET_ADDR + `ACX_STATUS_OK + s_reg.frm[1]);

  // frame checks on the last byte
  assign frame_ok = (rx_data == s_reg.sum) && (s_reg.frm[0] == `ACX_TARGET_ADDR)
                    && ((s_reg.frm[1] == `ACX_INSTR_ACCU) || (s_reg.frm[1] == `ACX_INSTR_UVAR))
                    && (s_reg.frm[2] <= `ACX_TYPE_MAX);

  // =============================================
  // Next state
  always_comb
  begin
    s_next = s_reg;
    var_we = 1'b0;
    var_wi = var_idx;
    var_wd = var_wdata;
    case (s_reg.state)
      ACX_ST_RX:
      begin
        if (rx_valid)
        begin
          s_next.frm[s_reg.cnt] = rx_data;
          s_next.sum = s_reg.sum + rx_data;
          s_next.cnt = s_reg.cnt + 4'h1;
          if (s_reg.cnt == `ACX_LAST_BYTE)
          begin
            s_next.cnt = 4'h0;
            s_next.sum = 8'h00;
            if (frame_ok)
            begin
              s_next.state = ACX_ST_EXEC;
            end
          end
        end
        if (xreg_wr)
        begin
          s_next.xreg = xreg_wdata;
        end
        if (accu_wr)
        begin
          s_next.accu = accu_wdata;
        end
        var_we = var_wr;
      end
      ACX_ST_EXEC:
      begin
        var_wi = s_reg.frm[3];
        if (acx_op_t'(op_code) == ACX_OP_SWAP)
        begin
          var_we = 1'b1;
          if (to_accu)
          begin
            var_wd = s_reg.accu;
            s_next.accu = var_rd;
          end
          else
          begin
            var_wd = s_reg.xreg;
            s_next.xreg = var_rd;
          end
        end
        else if (acx_op_t'(op_code) != ACX_OP_COMP)
        begin
          if (to_accu)
          begin
            s_next.accu = res;
          end
          else
          begin
            var_we = 1'b1;
            var_wd = res;
          end
        end
        s_next.frm[0] = `ACX_HOST_ADDR;
        s_next.frm[1] = `ACX_TARGET_ADDR;
        s_next.frm[2] = `ACX_STATUS_OK;
        s_next.frm[3] = s_reg.frm[1];
        s_next.frm[4] = 8'h00;
        s_next.frm[5] = 8'h00;
        s_next.frm[6] = 8'h00;
        s_next.frm[7] = 8'h00;
        s_next.frm[8] = rsum;
        s_next.txb = `ACX_HOST_ADDR;
        s_next.cnt = 4'h0;
        s_next.state = ACX_ST_TX;
      end
      ACX_ST_TX:
      begin
        if (tx_ready)
        begin
          s_next.cnt = s_reg.cnt + 4'h1;
          s_next.txb = s_reg.frm[4'(s_reg.cnt + 4'h1)];
          if (s_reg.cnt == `ACX_LAST_BYTE)
          begin
            s_next.cnt = 4'h0;
            s_next.txb = 8'h00;
            s_next.state = ACX_ST_RX;
          end
        end
      end
      default:
      begin
        s_next.state = ACX_ST_RX;
      end
    endcase
  end

  // =============================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_reg <= '{state: ACX_ST_RX, cnt: 4'h0, frm: '0, sum: 8'h00, txb: 8'h00,
                 accu: `ACX_ACCU_RESET, xreg: `ACX_XREG_RESET};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (var_we)
    begin
      vars[var_wi] <= var_wd;
    end
    var_rdata <= vars[var_idx];
  end

endmodule
